/* File: bench/sps_loc_store.sv */
// Purpose: Location store model on the far side of the lookup
// Assumes: Combinational answer, settled before the next edge
// Notes:   Location 0d and the commanded hole read as empty
`timescale 1ns/1ns
`default_nettype none
module sps_loc_store
    import sps_pkg::*;
(
    // Lookup
    input  wire logic [7:0] locAddr,
    input  wire logic [7:0] holeAddr,
    output sps_loc_t        locData
);
    // Voltage echoes the address so the bench can trace the walk
    always_comb begin
        locData.valid   = 1'b1;
        locData.empty   = (locAddr == 8'h0d) || (locAddr == holeAddr);
        locData.voltage = {8'h00, locAddr};
        locData.current = {8'h00, ~locAddr};
        locData.dwell   = (locAddr == 8'h0c) ? 14'h0002 : (locAddr == 8'h0f) ? 14'h0010 : 14'h0000;
    end
endmodule : sps_loc_store
`default_nettype wire

/* File: bench/sps_sequencer_sva.sv */
// Purpose: Port-level assertions for the setpoint sequencer
// Assumes: Zero-wait bus slave, one clock domain
// Notes:   Counters stand in for long hold and blink times
`timescale 1ns/1ns
`default_nettype none
module sps_sequencer_sva
    import sps_pkg::*;
#(
    parameter int ERR_CYC  = 100,
    parameter int SLOW_CYC = 20
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        srst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Sequencer side
    input wire logic [7:0]  locAddr,
    input wire sps_loc_t    locData,
    input wire logic [7:0]  storeAddr,
    input wire logic        storePulse,
    input wire logic [7:0]  setupRepeat,
    input wire logic        setupWrite,
    input wire sps_out_t    powerOut,
    input wire logic        readyLamp,
    input wire logic        errorShow
);
    logic        ctrlWr_r;
    logic [7:0]  snap_r;
    logic [15:0] errCnt_r;
    logic [15:0] lowCnt_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Data phase of a command write, with the store address it saw
    always_ff @(posedge sys_clk) begin
        ctrlWr_r <= !srst && hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
        if (ctrlWr_r) begin
            snap_r <= storeAddr;
        end
    end
    // Length of the error display
    always_ff @(posedge sys_clk) begin
        errCnt_r <= (srst || !errorShow) ? 16'h0000 : errCnt_r + 16'h0001;
    end
    // Length of a dark lamp phase; idle keeps it lit
    always_ff @(posedge sys_clk) begin
        lowCnt_r <= (srst || readyLamp) ? 16'h0000 : lowCnt_r + 16'h0001;
    end
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not zero-wait OKAY");
    property p_reset; $fell(srst) |-> locAddr == 8'h0b && readyLamp && !powerOut.on && hrdata == 32'h0; endproperty
    a_reset: assert property (p_reset) else $error("wrong state after reset");
    property p_ptr; locAddr >= 8'h0b; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer below lowest location");
    property p_store; ctrlWr_r && hwdata[6] |=> storePulse; endproperty
    a_store: assert property (p_store) else $error("no store pulse");
    property p_inc; ctrlWr_r && hwdata[6] |-> ##[2:3] storeAddr == snap_r + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("store address not advanced by one");
    property p_save; ctrlWr_r && hwdata[5] |=> setupWrite; endproperty
    a_save: assert property (p_save) else $error("no setup write on save");
    property p_err; $fell(errorShow) |-> errCnt_r >= ERR_CYC - 1 && errCnt_r <= ERR_CYC + 1; endproperty
    a_err: assert property (p_err) else $error("error display length wrong");
    property p_lamp; lowCnt_r <= SLOW_CYC + 1; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp dark too long");
    property p_rdata; $changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite); endproperty
    a_rdata: assert property (p_rdata) else $error("read data changed without a read");
    // Main scenarios reached
    c_err: cover property ($fell(errorShow));
    c_store: cover property (storePulse);
    c_blink: cover property ($fell(readyLamp));
    c_off: cover property ($fell(powerOut.on));
endmodule : sps_sequencer_sva
bind sps_sequencer sps_sequencer_sva #(.ERR_CYC(ERR_CYC), .SLOW_CYC(SLOW_CYC)) sps_sequencer_sva_inst (
    .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .locAddr(locAddr), .locData(locData), .storeAddr(storeAddr), .storePulse(storePulse),
    .setupRepeat(setupRepeat), .setupWrite(setupWrite), .powerOut(powerOut), .readyLamp(readyLamp),
    .errorShow(errorShow));
`default_nettype wire

/* File: bench/test_setpoint_sequencer.sv */
// Purpose: Self-checking bench for the setpoint sequencer
// Assumes: Zero-wait slave, store model answers at once
// Notes:   Shortened hold, tick and blink counts keep the run brief
`include "sps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module test_setpoint_sequencer
    import sps_pkg::*;
;
    logic        sys_clk, srst, hsel, hwrite, hreadyout, hresp;
    logic        storePulse, setupWrite, readyLamp, errorShow;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  holeAddr, locAddr, storeAddr, setupRepeat;
    logic [15:0] lastV = 16'h0000;
    logic [15:0] vlog[$];
    sps_loc_t    locData;
    sps_out_t    powerOut;
    int          fail_count = 0, comparisons = 0, storeSeen = 0, saveSeen = 0;
    // 10 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    sps_sequencer #(.ERR_CYC(100), .TICK_CYC(4), .SLOW_CYC(20), .FAST_CYC(5)) sps_sequencer_inst (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .locAddr(locAddr), .locData(locData), .storeAddr(storeAddr), .storePulse(storePulse),
        .setupRepeat(setupRepeat), .setupWrite(setupWrite), .powerOut(powerOut), .readyLamp(readyLamp),
        .errorShow(errorShow));
    sps_loc_store sps_loc_store_inst (.locAddr(locAddr), .holeAddr(holeAddr), .locData(locData));
    // Trace each applied voltage; pulses are too short to poll
    always @(posedge sys_clk) begin
        if (powerOut.voltage !== lastV) begin
            vlog.push_back(powerOut.voltage);
        end
        lastV <= powerOut.voltage;
        storeSeen <= storeSeen + (storePulse === 1'b1);
        saveSeen <= saveSeen + (setupWrite === 1'b1);
    end
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic wait_ready();
        repeat (20) begin
            @(posedge sys_clk);
            if (hreadyout === 1'b1) begin
                return;
            end
        end
        fail_count++;
        $display("[ERR] t=%0t bus hang", $time);
        stop_test();
    endtask : wait_ready
    // One word transfer; read data lands in rd at the data phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus
    task automatic cmd(input int b);
        bus(1'b1, `SPS_OFF_CTRL, 32'h1 << b);
    endtask : cmd
    task automatic wait_state(input logic [2:0] s);
        repeat (150) begin
            bus(1'b0, `SPS_OFF_STATUS, 32'h0);
            if (rd[2:0] === s) begin
                return;
            end
        end
        fail_count++;
        $display("[ERR] t=%0t state wait timed out", $time);
        stop_test();
    endtask : wait_state
    task automatic toggles(output int n);
        logic p;
        n = 0;
        p = readyLamp;
        repeat (20) begin
            @(posedge sys_clk);
            n += int'(readyLamp !== p);
            p = readyLamp;
        end
    endtask : toggles
    task automatic test_limits();
        bus(1'b0, `SPS_OFF_STATUS, 32'h0);
        `CHK(rd[23:16], 8'h0b)
        bus(1'b1, `SPS_OFF_FIRST, 32'h0a);
        bus(1'b1, `SPS_OFF_TERM, 32'h10a);
        bus(1'b1, `SPS_OFF_TERM, 32'h0a);
        bus(1'b0, `SPS_OFF_FIRST, 32'h0);
        `CHK(rd[7:0], 8'h0b)
        bus(1'b0, `SPS_OFF_TERM, 32'h0);
        `CHK(rd[7:0], 8'hff)
        bus(1'b1, `SPS_OFF_TERM, 32'h0b);
        bus(1'b0, `SPS_OFF_TERM, 32'h0);
        `CHK(rd[7:0], 8'h0b)
        bus(1'b1, `SPS_OFF_FIRST, 32'h0c);
        bus(1'b1, `SPS_OFF_TERM, 32'h0f);
        bus(1'b0, `SPS_OFF_FIRST, 32'h0);
        `CHK(rd[7:0], 8'h0c)
        bus(1'b0, `SPS_OFF_TERM, 32'h0);
        `CHK(rd[7:0], 8'h0f)
        $display("test_limits done");
    endtask : test_limits
    task automatic test_auto();
        logic [15:0] expV[6] = '{16'h0c, 16'h0e, 16'h0f, 16'h0c, 16'h0e, 16'h0f};
        int n;
        bus(1'b1, `SPS_OFF_REPEAT, 32'h02);
        cmd(`SPS_CMD_LAUNCH);
        vlog.delete();
        bus(1'b0, `SPS_OFF_COND_A, 32'h0);
        `CHK(rd[7], 1'b1)
        toggles(n);
        `CHK(n >= 3, 1'b1)
        wait_state(3'b001);
        foreach (expV[i]) begin
            `CHK(vlog[i], expV[i])
        end
        `CHK(vlog.size(), 6)
        `CHK(powerOut.on, 1'b1)
        $display("test_auto done");
    endtask : test_auto
    task automatic test_step();
        int n;
        logic [7:0] left;
        bus(1'b1, `SPS_OFF_TERM, 32'h12);
        cmd(`SPS_CMD_STEP);
        wait_state(3'b100);
        left = rd[15:8];
        `CHK(powerOut.voltage, 16'h0c)
        `CHK(powerOut.on, 1'b1)
        `CHK(powerOut.current, 16'h00f3)
        toggles(n);
        `CHK(n <= 1, 1'b1)
        cmd(`SPS_CMD_STEP);
        bus(1'b0, `SPS_OFF_STATUS, 32'h0);
        `CHK(rd[23:16], 8'h0e)
        `CHK(rd[2:0], 3'b100)
        `CHK(rd[15:8], left)
        cmd(`SPS_CMD_RESUME);
        bus(1'b0, `SPS_OFF_STATUS, 32'h0);
        `CHK(rd[23:16], 8'h0f)
        cmd(`SPS_CMD_HOLD);
        cmd(`SPS_CMD_LAUNCH);
        bus(1'b0, `SPS_OFF_STATUS, 32'h0);
        `CHK(rd[2:0], 3'b010)
        cmd(`SPS_CMD_FAULT);
        bus(1'b0, `SPS_OFF_EVENT_B, 32'h0);
        `CHK(rd[5], 1'b1)
        bus(1'b0, `SPS_OFF_EVENT_B, 32'h0);
        `CHK(rd[5], 1'b0)
        `CHK(errorShow, 1'b1)
        cmd(`SPS_CMD_TERM);
        wait_state(3'b001);
        `CHK(powerOut.voltage, 16'h12)
        $display("test_step done");
    endtask : test_step
    task automatic test_end();
        int s;
        holeAddr <= 8'h12;
        bus(1'b1, `SPS_OFF_REPEAT, 32'h03);
        s = saveSeen;
        cmd(`SPS_CMD_SAVE);
        bus(1'b1, `SPS_OFF_REPEAT, 32'h00);
        `CHK(setupRepeat, 8'h03)
        cmd(`SPS_CMD_LAUNCH);
        `CHK(saveSeen - s, 1)
        repeat (300) @(posedge sys_clk);
        bus(1'b0, `SPS_OFF_STATUS, 32'h0);
        `CHK(rd[2:0], 3'b010)
        cmd(`SPS_CMD_TERM);
        wait_state(3'b001);
        `CHK(powerOut.on, 1'b0)
        bus(1'b1, `SPS_OFF_STORE, 32'h20);
        s = storeSeen;
        cmd(`SPS_CMD_STORE);
        bus(1'b0, `SPS_OFF_STORE, 32'h0);
        `CHK(rd[7:0], 8'h21)
        `CHK(storeSeen - s, 1)
        $display("test_end done");
    endtask : test_end
    task automatic test_reset();
        cmd(`SPS_CMD_LAUNCH);
        srst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        bus(1'b0, `SPS_OFF_STATUS, 32'h0);
        `CHK(rd[2:0], 3'b001)
        `CHK(rd[23:16], 8'h0b)
        bus(1'b0, `SPS_OFF_COND_A, 32'h0);
        `CHK(rd[7], 1'b0)
        $display("test_reset done");
    endtask : test_reset
    initial begin
        srst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        holeAddr = 8'h00;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        test_limits();
        test_auto();
        test_step();
        test_end();
        test_reset();
        stop_test();
    end
endmodule : test_setpoint_sequencer
`default_nettype wire

/* File: logic/sps_cfg.svh */
// Purpose: Constants of the setpoint sequencer
// Assumes: 10 MHz system clock
// Notes:   Register offsets are byte addresses on AHB-Lite
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH
`define SPS_ADDR_MIN      8'h0b
`define SPS_ADDR_MAX      8'hff
`define SPS_CLK_HZ        10000000
`define SPS_ERR_HOLD_MS   1000
`define SPS_DWELL_TICK_US 10000
`define SPS_SLOW_HALF_MS  500
`define SPS_FAST_HALF_MS  125
`define SPS_OFF_CTRL      8'h00
`define SPS_OFF_FIRST     8'h04
`define SPS_OFF_TERM      8'h08
`define SPS_OFF_REPEAT    8'h0c
`define SPS_OFF_COND_A    8'h10
`define SPS_OFF_EVENT_B   8'h14
`define SPS_OFF_STATUS    8'h18
`define SPS_OFF_STORE     8'h1c
`define SPS_BIT_ACTIVE    7
`define SPS_BIT_FAULT     5
`define SPS_CMD_LAUNCH    0
`define SPS_CMD_RESUME    1
`define SPS_CMD_STEP      2
`define SPS_CMD_TERM      3
`define SPS_CMD_HOLD      4
`define SPS_CMD_SAVE      5
`define SPS_CMD_STORE     6
`define SPS_CMD_FAULT     7
`define SPS_REP_CONT      8'h00
`endif

/* File: logic/sps_pkg.sv */
// Purpose: Types of the setpoint sequencer
// Assumes: Included with sps_cfg.svh
// Notes:   One-hot state codes
`default_nettype none
package sps_pkg;
    typedef enum logic [2:0] {
        SPS_IDLE    = 3'b001,
        SPS_RUN     = 3'b010,
        SPS_SUSPEND = 3'b100
    } sps_state_t;
    typedef struct packed {
        logic        valid;
        logic        empty;
        logic [15:0] voltage;
        logic [15:0] current;
        logic [13:0] dwell;
    } sps_loc_t;
    typedef struct packed {
        logic        on;
        logic [15:0] voltage;
        logic [15:0] current;
    } sps_out_t;
endpackage : sps_pkg
`default_nettype wire

/* File: logic/sps_sequencer.sv */
// Purpose: Setpoint sequencer with AHB-Lite register slave
// Assumes: Location store answers lookups combinationally, before the next edge
// Notes:   Panel and remote commands arrive as bus writes
`include "sps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module sps_sequencer
    import sps_pkg::*;
#(
    parameter int ERR_CYC  = `SPS_CLK_HZ / 1000 * `SPS_ERR_HOLD_MS,
    parameter int TICK_CYC = `SPS_CLK_HZ / 1000000 * `SPS_DWELL_TICK_US,
    parameter int SLOW_CYC = `SPS_CLK_HZ / 1000 * `SPS_SLOW_HALF_MS,
    parameter int FAST_CYC = `SPS_CLK_HZ / 1000 * `SPS_FAST_HALF_MS
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Location store lookup
    output logic      [7:0]  locAddr,
    input  wire sps_loc_t    locData,
    // Store address for setpoint saving
    output logic      [7:0]  storeAddr,
    output logic             storePulse,
    // Setup storage of repeats
    output logic      [7:0]  setupRepeat,
    output logic             setupWrite,
    // Power and signal output setpoints
    output sps_out_t         powerOut,
    // Front lamp and error display
    output logic             readyLamp,
    output logic             errorShow
);
    sps_state_t  state_r;
    logic [7:0]  firstAddr_r, termAddr_r, repeat_r, repeatsLeft_r, ptr_r, storeAddr_r, setupRep_r;
    logic        singleMode_r, fault_r, busWr_r, busRd_r, cmdStore_r, setupWr_r;
    logic [7:0]  busAddr_r;
    logic [31:0] hrdata_r;
    logic        lookBusy_r;
    logic [1:0]  lookKind_r;
    logic [13:0] dwellLeft_r;
    logic [$clog2(TICK_CYC+1)-1:0] tickCnt_r;
    logic [$clog2(ERR_CYC+1)-1:0]  errCnt_r;
    logic [$clog2(SLOW_CYC+1)-1:0] blinkCnt_r;
    logic        blink_r, dwellRun_r;
    sps_out_t    out_r;
    logic [7:0]  cmd;
    logic        wrCtrl, busTake;
    logic [13:0] dwellPick;
    logic [7:0]  cmdPend_r, cmdSeq;

    // Lookup kinds: advance normally, land on terminal
    localparam logic [1:0] LK_ADV = 2'h0;
    localparam logic [1:0] LK_TERM = 2'h1;

    // Bus always answers in one cycle, so no wait states are ever needed
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign busTake   = hsel & hready & htrans[1];

    // Address phase capture
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busWr_r   <= 1'b0;
            busRd_r   <= 1'b0;
            busAddr_r <= 8'h00;
        end else begin
            busWr_r   <= busTake & hwrite;
            busRd_r   <= busTake & ~hwrite;
            busAddr_r <= haddr[7:0];
        end
    end

    assign wrCtrl = busWr_r && busAddr_r == `SPS_OFF_CTRL;
    assign cmd    = wrCtrl ? hwdata[7:0] : 8'h00;

    // Address and repeat settings, kept until rewritten
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            firstAddr_r <= `SPS_ADDR_MIN;
            termAddr_r  <= `SPS_ADDR_MAX;
            repeat_r    <= 8'h01;
        end else if (busWr_r) begin
            if (busAddr_r == `SPS_OFF_FIRST && hwdata[7:0] >= `SPS_ADDR_MIN && hwdata[31:8] == 24'h0)
                firstAddr_r <= hwdata[7:0];
            if (busAddr_r == `SPS_OFF_TERM && hwdata[7:0] >= `SPS_ADDR_MIN && hwdata[31:8] == 24'h0)
                termAddr_r <= hwdata[7:0];
            if (busAddr_r == `SPS_OFF_REPEAT)
                repeat_r <= hwdata[7:0];
        end
    end

    // Setup save of the repeat count
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            setupRep_r <= 8'h00;
            setupWr_r  <= 1'b0;
        end else begin
            setupWr_r <= cmd[`SPS_CMD_SAVE];
            if (cmd[`SPS_CMD_SAVE])
                setupRep_r <= repeat_r;
        end
    end

    // Store address auto increment after each setpoint store, holding at the top address 8'hff
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            storeAddr_r <= `SPS_ADDR_MIN;
            cmdStore_r  <= 1'b0;
        end else begin
            cmdStore_r <= cmd[`SPS_CMD_STORE];
            if (busWr_r && busAddr_r == `SPS_OFF_STORE && hwdata[7:0] >= `SPS_ADDR_MIN)
                storeAddr_r <= hwdata[7:0];
            else if (cmdStore_r && storeAddr_r != `SPS_ADDR_MAX)
                storeAddr_r <= storeAddr_r + 8'h01;
        end
    end

    // Register read mux; unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (srst)
            hrdata_r <= 32'h0;
        else if (busTake & ~hwrite) begin
            case (haddr[7:0])
                `SPS_OFF_FIRST:   hrdata_r <= {24'h0, firstAddr_r};
                `SPS_OFF_TERM:    hrdata_r <= {24'h0, termAddr_r};
                `SPS_OFF_REPEAT:  hrdata_r <= {24'h0, repeat_r};
                `SPS_OFF_COND_A:  hrdata_r <= {24'h0, (state_r != SPS_IDLE), 7'h0};
                `SPS_OFF_EVENT_B: hrdata_r <= {26'h0, fault_r, 5'h0};
                `SPS_OFF_STATUS:  hrdata_r <= {8'h0, ptr_r, repeatsLeft_r, 5'h0, state_r};
                `SPS_OFF_STORE:   hrdata_r <= {24'h0, storeAddr_r};
                default:          hrdata_r <= 32'h0;
            endcase
        end
    end

    // Fault flag: a new fault wins over a read-to-clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst)
            fault_r <= 1'b0;
        else if (cmd[`SPS_CMD_FAULT] && state_r != SPS_IDLE)
            fault_r <= 1'b1;
        else if (busRd_r && busAddr_r == `SPS_OFF_EVENT_B)
            fault_r <= 1'b0;
    end

    // Error display held about one second after a fault
    always_ff @(posedge sys_clk) begin
        if (srst)
            errCnt_r <= '0;
        else if (cmd[`SPS_CMD_FAULT] && state_r != SPS_IDLE)
            errCnt_r <= ($bits(errCnt_r))'(ERR_CYC);
        else if (errCnt_r != '0)
            errCnt_r <= errCnt_r - 1'b1;
    end

    assign dwellPick = (locData.dwell != 14'h0) ? locData.dwell : 14'h0;

    // Commands that land during a lookup wait for it, so a stop is never lost
    always_ff @(posedge sys_clk) begin
        if (srst)
            cmdPend_r <= 8'h00;
        else
            cmdPend_r <= lookBusy_r ? (cmdPend_r | cmd) : 8'h00;
    end
    assign cmdSeq = cmd | cmdPend_r;

    // Sequence state machine with location lookup and dwell timing
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r       <= SPS_IDLE;
            ptr_r         <= `SPS_ADDR_MIN;
            repeatsLeft_r <= 8'h00;
            singleMode_r  <= 1'b0;
            lookBusy_r    <= 1'b0;
            lookKind_r    <= LK_ADV;
            dwellLeft_r   <= 14'h0;
            dwellRun_r    <= 1'b0;
            tickCnt_r     <= '0;
            out_r         <= '0;
        end else begin
            if (state_r == SPS_IDLE && !lookBusy_r)
                ptr_r <= firstAddr_r;
            // Dwell countdown in ticks of ten milliseconds
            if (dwellRun_r && !lookBusy_r) begin
                if (tickCnt_r == '0) begin
                    tickCnt_r <= ($bits(tickCnt_r))'(TICK_CYC - 1);
                    if (dwellLeft_r != 14'h0)
                        dwellLeft_r <= dwellLeft_r - 14'h1;
                end else
                    tickCnt_r <= tickCnt_r - 1'b1;
            end
            if (lookBusy_r) begin
                // Location data for ptr_r arrives this cycle
                lookBusy_r <= 1'b0;
                if (lookKind_r == LK_TERM) begin
                    if (!locData.empty)
                        out_r <= '{on: out_r.on, voltage: locData.voltage, current: locData.current};
                    else
                        out_r.on <= 1'b0;
                    state_r    <= SPS_IDLE;
                    dwellRun_r <= 1'b0;
                end else if (locData.empty && ptr_r != termAddr_r) begin
                    ptr_r      <= ptr_r + 8'h01;
                    lookBusy_r <= 1'b1;
                end else if (locData.empty && (singleMode_r || repeat_r == `SPS_REP_CONT || repeatsLeft_r > 8'h01)) begin
                    ptr_r      <= firstAddr_r;
                    lookBusy_r <= 1'b1;
                    if (!singleMode_r && repeat_r != `SPS_REP_CONT)
                        repeatsLeft_r <= repeatsLeft_r - 8'h01;
                end else if (locData.empty) begin
                    out_r.on   <= 1'b0;
                    state_r    <= SPS_IDLE;
                    dwellRun_r <= 1'b0;
                end else begin
                    out_r       <= '{on: 1'b1, voltage: locData.voltage, current: locData.current};
                    dwellLeft_r <= (locData.dwell != 14'h0) ? dwellPick : locData.dwell;
                    dwellRun_r  <= state_r == SPS_RUN;
                    tickCnt_r   <= ($bits(tickCnt_r))'(TICK_CYC - 1);
                end
            end else if (cmdSeq[`SPS_CMD_TERM] && state_r != SPS_IDLE) begin
                ptr_r      <= termAddr_r;
                lookKind_r <= LK_TERM;
                lookBusy_r <= 1'b1;
            end else begin
                case (state_r)
                    SPS_IDLE: begin
                        if (cmdSeq[`SPS_CMD_LAUNCH] || cmdSeq[`SPS_CMD_STEP]) begin
                            state_r       <= cmdSeq[`SPS_CMD_LAUNCH] ? SPS_RUN : SPS_SUSPEND;
                            singleMode_r  <= ~cmdSeq[`SPS_CMD_LAUNCH];
                            ptr_r         <= firstAddr_r;
                            repeatsLeft_r <= repeat_r;
                            lookKind_r    <= LK_ADV;
                            lookBusy_r    <= 1'b1;
                        end
                    end
                    SPS_RUN: begin
                        if (cmdSeq[`SPS_CMD_HOLD] || cmdSeq[`SPS_CMD_STEP]) begin
                            state_r      <= SPS_SUSPEND;
                            dwellRun_r   <= 1'b0;
                            singleMode_r <= cmdSeq[`SPS_CMD_STEP];
                        end else if (cmdSeq[`SPS_CMD_LAUNCH]) begin
                            ptr_r         <= firstAddr_r;
                            repeatsLeft_r <= repeat_r;
                            lookKind_r    <= LK_ADV;
                            lookBusy_r    <= 1'b1;
                        end else if (dwellRun_r && dwellLeft_r == 14'h0 && tickCnt_r == '0) begin
                            lookKind_r <= LK_ADV;
                            lookBusy_r <= 1'b1;
                            if (ptr_r != termAddr_r)
                                ptr_r <= ptr_r + 8'h01;
                            else if (repeat_r == `SPS_REP_CONT || repeatsLeft_r > 8'h01) begin
                                ptr_r <= firstAddr_r;
                                if (repeat_r != `SPS_REP_CONT)
                                    repeatsLeft_r <= repeatsLeft_r - 8'h01;
                            end else begin
                                lookBusy_r <= 1'b0;
                                state_r    <= SPS_IDLE;
                                dwellRun_r <= 1'b0;
                            end
                        end
                    end
                    SPS_SUSPEND: begin
                        if (cmdSeq[`SPS_CMD_RESUME] || cmdSeq[`SPS_CMD_STEP]) begin
                            state_r      <= cmdSeq[`SPS_CMD_RESUME] ? SPS_RUN : SPS_SUSPEND;
                            singleMode_r <= cmdSeq[`SPS_CMD_STEP];
                            lookKind_r   <= LK_ADV;
                            lookBusy_r   <= 1'b1;
                            ptr_r        <= (ptr_r != termAddr_r) ? ptr_r + 8'h01 : firstAddr_r;
                        end else if (cmdSeq[`SPS_CMD_LAUNCH]) begin
                            state_r       <= SPS_RUN;
                            singleMode_r  <= 1'b0;
                            ptr_r         <= firstAddr_r;
                            repeatsLeft_r <= repeat_r;
                            lookKind_r    <= LK_ADV;
                            lookBusy_r    <= 1'b1;
                        end
                    end
                    default: state_r <= SPS_IDLE;
                endcase
            end
        end
    end

    // Lamp blink generator; slow when suspended, fast when running
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            blinkCnt_r <= '0;
            blink_r    <= 1'b0;
        end else if (state_r == SPS_IDLE) begin
            blinkCnt_r <= '0;
            blink_r    <= 1'b0;
        end else if (blinkCnt_r == '0) begin
            blink_r    <= ~blink_r;
            blinkCnt_r <= (state_r == SPS_RUN) ? ($bits(blinkCnt_r))'(FAST_CYC - 1)
                                               : ($bits(blinkCnt_r))'(SLOW_CYC - 1);
        end else
            blinkCnt_r <= blinkCnt_r - 1'b1;
    end

    // Outputs
    assign locAddr     = ptr_r;
    assign storeAddr   = storeAddr_r;
    assign storePulse  = cmdStore_r;
    assign setupRepeat = setupRep_r;
    assign setupWrite  = setupWr_r;
    assign powerOut    = out_r;
    assign readyLamp   = (state_r == SPS_IDLE) ? 1'b1 : blink_r;
    assign errorShow   = errCnt_r != '0;
endmodule : sps_sequencer
`default_nettype wire
